// ### host_command_model.sv
// host computer model issuing commands on the register port
// assumes one clock and a slave that never stalls
`timescale 1ns/10ps
`default_nettype none
module host_command_model (
  input wire logic clk_in,
  input wire logic [31:0] rdata_in,
  output logic [3:0] addr_out,
  output logic [31:0] wdata_out,
  output logic wr_out,
  output logic rd_out
);
  // ************************************************************
  // bus cycles
  // ************************************************************
  initial begin
    addr_out = 4'h0;
    wdata_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic write_word(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= v;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
  endtask
  // data only stand in the cycle after the strobe
  task automatic read_word(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 v = rdata_in;
  endtask
  // no query chained behind: a read leaves local mode as it is
  task automatic go_local;
    write_word(step_function_pkg::REG_CMD, 32'h0000_0010);
    @(posedge clk_in);
  endtask
endmodule // host_command_model
`default_nettype wire

// ### sequence_step_function_engine_tb_top.sv
// self-checking bench for the step function engine
// assumes the host model drives the port and the checker is bound
`timescale 1ns/10ps
`default_nettype none
module sequence_step_function_engine_tb_top;
  logic clk_in, sys_rst_in, wr, rd, oe, run, loc;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, d;
  logic [15:0] vset, iset;
  logic [1:0] av, ai;
  logic bad_vset = 1'b0;
  logic [31:0] seq_cfg = 32'h0001_0500;
  int n_errors = 0;
  int checked = 0;
  step_function_engine #(.TICK(2)) step_function_engine_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr),
    .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
    .vset_out(vset), .iset_out(iset), .output_enable_setting_out(oe),
    .analog_voltage_input_out(av), .analog_current_input_out(ai),
    .running_out(run), .local_mode_out(loc));
  host_command_model host_command_model_i (
    .clk_in(clk_in), .rdata_in(rdata), .addr_out(addr),
    .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  // ************************************************************
  // helpers
  // ************************************************************
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // skipped slots carry all-ones volts, which must never show
  always @(posedge clk_in) begin
    if (run === 1'b1 && vset === 16'hFFFF) begin
      bad_vset <= 1'b1;
    end
  end
  task automatic tally_and_finish;
    if (n_errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic hw(input logic [3:0] a, input logic [31:0] v);
    host_command_model_i.write_word(a, v);
  endtask
  task automatic hr(input logic [3:0] a);
    host_command_model_i.read_word(a, d);
  endtask
  // six slots, stop where seq_cfg says; iset sits 0x100 above vset
  task automatic run_seq(input logic [4:0] c [6], input logic eo,
      input logic [1:0] ea, input logic [1:0] ei, input logic [15:0] ev);
    int k;
    for (k = 0; k < 6; k++) begin
      hw(step_function_pkg::REG_ADDR, 32'(k));
      hw(step_function_pkg::REG_WORK_CODE, {27'h0, c[k]});
      hw(step_function_pkg::REG_WORK_VSET, (c[k] == 5'h00) ?
        32'h0000_FFFF : 32'h100 + 32'(k));
      hw(step_function_pkg::REG_WORK_ISET, 32'h200 + 32'(k));
      hw(step_function_pkg::REG_WORK_TIME, 32'h1);
      hw(step_function_pkg::REG_CMD, 32'h1);
    end
    hw(step_function_pkg::REG_SEQ_CFG, seq_cfg);
    hw(step_function_pkg::REG_CMD, 32'h4);
    #1;
    k = 0;
    while (run === 1'b1 && k < 1000) begin
      @(posedge clk_in);
      k++;
    end
    #1;
    check("run end", 32'h0, {31'h0, run});
    check("enable", {31'h0, eo}, {31'h0, oe});
    check("analog v", {30'h0, ea}, {30'h0, av});
    check("analog i", {30'h0, ei}, {30'h0, ai});
    check("vset", {16'h0, ev}, {16'h0, vset});
    check("iset", {16'h0, ev + 16'h0100}, {16'h0, iset});
  endtask
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    sys_rst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    hr(step_function_pkg::REG_WORK_CODE);
    check("reset code", 32'h0, d);
    for (int c = 0; c < 14; c++) begin
      hw(step_function_pkg::REG_WORK_CODE, 32'(c));
      hr(step_function_pkg::REG_WORK_CODE);
      check("code echo", 32'(c), d);
    end
    hw(step_function_pkg::REG_WORK_CODE, 32'h0000_000E);
    hw(step_function_pkg::REG_WORK_CODE, 32'h0000_0025);
    hr(step_function_pkg::REG_WORK_CODE);
    check("bad code", 32'h0000_000D, d);
    hw(step_function_pkg::REG_WORK_CODE, 32'h0000_0005);
    hw(step_function_pkg::REG_CMD, 32'h1);
    repeat (4) @(posedge clk_in);
    check("idle enable", 32'h0, {31'h0, oe});
    run_seq('{5'h01, 5'h05, 5'h07, 5'h0B, 5'h00, 5'h00},
      1'b0, 2'h1, 2'h2, 16'h0103);
    hw(step_function_pkg::REG_ADDR, 32'h4);
    hr(step_function_pkg::REG_READBACK);
    check("empty slot", 32'h0000_FFFF, d);
    hw(step_function_pkg::REG_ADDR, 32'h0);
    hr(step_function_pkg::REG_READBACK);
    check("plain slot", 32'h0001_0100, d);
    run_seq('{5'h05, 5'h08, 5'h0A, 5'h02, 5'h03, 5'h01},
      1'b1, 2'h2, 2'h1, 16'h0105);
    run_seq('{5'h04, 5'h06, 5'h09, 5'h01, 5'h01, 5'h01},
      1'b0, 2'h0, 2'h0, 16'h0105);
    // slot 1 calls slots 4..5 once, then the run ends at slot 3
    seq_cfg = 32'h0001_0300;
    hw(step_function_pkg::REG_SEQ_CFG, 32'h0001_0504);
    hw(step_function_pkg::REG_CMD, 32'h2);
    run_seq('{5'h01, 5'h0D, 5'h01, 5'h01, 5'h07, 5'h05},
      1'b1, 2'h1, 2'h0, 16'h0103);
    // same setup with a power function: the chain aborts the run
    hw(step_function_pkg::REG_CTRL, 32'h1);
    hw(step_function_pkg::REG_SEQ_CFG, 32'h0001_0504);
    hw(step_function_pkg::REG_CMD, 32'h2);
    hw(step_function_pkg::REG_CTRL, 32'h0);
    run_seq('{5'h04, 5'h0C, 5'h05, 5'h01, 5'h01, 5'h01},
      1'b0, 2'h1, 2'h0, 16'h0100);
    check("skip", 32'h0, {31'h0, bad_vset});
    hw(step_function_pkg::REG_CMD, 32'h4);
    hw(step_function_pkg::REG_CMD, 32'h8);
    repeat (4) @(posedge clk_in);
    check("abort", 32'h0, {31'h0, run});
    host_command_model_i.go_local();
    check("local", 32'h1, {31'h0, loc});
    hw(step_function_pkg::REG_CMD, 32'h20);
    #1;
    check("remote", 32'h0, {31'h0, loc});
    tally_and_finish();
  end
  // all tests need well under a tenth of this
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    tally_and_finish();
  end
endmodule // sequence_step_function_engine_tb_top
`default_nettype wire

// ### step_function_engine.sv
// sequencer with per-location step function codes
// assumes register master on clk_in; no pins from other domains
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module step_function_engine #(
  parameter int DEPTH_LOG2 = 4,
  parameter int SETUPS = 15,
  parameter int TICK = step_function_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic [15:0] vset_out,
  output logic [15:0] iset_out,
  output logic output_enable_setting_out,
  output logic [1:0] analog_voltage_input_out,
  output logic [1:0] analog_current_input_out,
  output logic running_out,
  output logic local_mode_out
);
  localparam int DEPTH = 1 << DEPTH_LOG2;
  typedef logic [DEPTH_LOG2-1:0] addr_t;
  typedef enum logic [2:0] {IDLE, ENTER, DWELL, FINISH} state_t;
  typedef struct packed {
    state_t st;
    logic [4:0] code;
    logic [15:0] vset;
    logic [15:0] iset;
    logic [15:0] step_dwell_time;
    addr_t loc;
    logic [3:0] setup_idx;
    logic power_fn;
    addr_t start_a;
    addr_t stop_a;
    logic [7:0] reps;
    logic [15:0] default_dwell_time;
    addr_t cur;
    logic [7:0] rep_cnt;
    logic in_sub;
    addr_t ret_a;
    addr_t m_start;
    addr_t m_stop;
    logic [7:0] m_reps;
    logic [7:0] m_cnt;
    logic [15:0] m_default_dwell_time;
    logic [31:0] tick;
    logic [15:0] dwell;
    logic [15:0] ramp_from;
    logic ramp_v;
    logic ramp_i;
    logic abort;
    logic [15:0] ov;
    logic [15:0] oi;
    logic oe;
    logic [1:0] av;
    logic [1:0] ai;
    logic local_m;
    logic run;
    logic [31:0] rd;
  } state_reg_t;
  state_reg_t s_r, s_nxt;
  // ************************************************************
  // location and setup memories
  // ************************************************************
  logic [4:0] m_code [DEPTH];
  logic [15:0] m_v [DEPTH];
  logic [15:0] m_i [DEPTH];
  logic [15:0] m_t [DEPTH];
  logic [5+2*DEPTH_LOG2+8+16+1-1:0] setup_mem [SETUPS];
  logic [4:0] setup_code [SETUPS][DEPTH];
  logic mem_we, setup_we, recall;
  logic [3:0] rec_idx;
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      m_code[s_r.loc] <= s_r.code;
      m_v[s_r.loc] <= s_r.vset;
      m_i[s_r.loc] <= s_r.iset;
      m_t[s_r.loc] <= s_r.step_dwell_time;
    end
    if (setup_we) begin
      setup_mem[s_r.setup_idx] <= {s_r.code, s_r.start_a, s_r.stop_a,
        s_r.reps, s_r.default_dwell_time, s_r.power_fn};
      for (int k = 0; k < DEPTH; k++) begin
        setup_code[s_r.setup_idx][k] <= m_code[k];
      end
    end
    if (recall) begin
      for (int k = 0; k < DEPTH; k++) begin
        m_code[k] <= setup_code[rec_idx][k];
      end
    end
  end
  function automatic logic code_ok(input logic [31:0] d);
    code_ok = (d[31:5] == 27'h0) &&
      (d[4:0] <= step_function_pkg::SUBSEQ_CODE);
  endfunction
  // signed step so that a falling ramp does not wrap around
  function automatic logic [15:0] ramp_step(input logic [15:0] cur_v,
      input logic [15:0] goal, input logic [15:0] left);
    logic signed [17:0] diff;
    diff = $signed({2'b00, goal}) - $signed({2'b00, cur_v});
    ramp_step = 16'($signed({2'b00, cur_v}) + diff / $signed({2'b00, left}));
  endfunction
  // ************************************************************
  // next state
  // ************************************************************
  logic [4:0] ecode;
  logic [15:0] ev, ei, et;
  logic [3:0] sidx;
  logic [5+2*DEPTH_LOG2+8+16+1-1:0] srec;
  always_comb begin
    s_nxt = s_r;
    mem_we = 1'b0;
    setup_we = 1'b0;
    recall = 1'b0;
    ecode = m_code[s_r.cur];
    ev = m_v[s_r.cur];
    ei = m_i[s_r.cur];
    et = m_t[s_r.cur];
    sidx = (et[3:0] == 4'h0) ? 4'h0 : et[3:0] - 4'h1;
    rec_idx = sidx;
    srec = setup_mem[sidx];
    s_nxt.rd = 32'h0;
    if (wr_in) begin
      case (addr_in)
        step_function_pkg::REG_CTRL:
          s_nxt.power_fn = wdata_in[step_function_pkg::CTRL_POWER_FN_BIT];
        step_function_pkg::REG_WORK_CODE:
          if (code_ok(wdata_in)) s_nxt.code = wdata_in[4:0];
        step_function_pkg::REG_WORK_VSET: s_nxt.vset = wdata_in[15:0];
        step_function_pkg::REG_WORK_ISET: s_nxt.iset = wdata_in[15:0];
        step_function_pkg::REG_WORK_TIME: s_nxt.step_dwell_time = wdata_in[15:0];
        step_function_pkg::REG_ADDR: begin
          s_nxt.loc = wdata_in[DEPTH_LOG2-1:0];
          s_nxt.setup_idx = wdata_in[11:8];
        end
        step_function_pkg::REG_SEQ_CFG: begin
          s_nxt.start_a = wdata_in[DEPTH_LOG2-1:0];
          s_nxt.stop_a = wdata_in[8+DEPTH_LOG2-1:8];
          s_nxt.reps = wdata_in[23:16];
        end
        step_function_pkg::REG_SETUP_CFG: s_nxt.default_dwell_time = wdata_in[15:0];
        step_function_pkg::REG_CMD: begin
          mem_we = wdata_in[step_function_pkg::CMD_STORE_BIT];
          setup_we = wdata_in[step_function_pkg::CMD_SETUP_STORE_BIT];
          if (wdata_in[step_function_pkg::CMD_LOCAL_BIT])
            s_nxt.local_m = 1'b1;
          if (wdata_in[step_function_pkg::CMD_REMOTE_BIT])
            s_nxt.local_m = 1'b0;
          if (wdata_in[step_function_pkg::CMD_START_BIT] &&
              s_r.st == IDLE) begin
            s_nxt.st = ENTER;
            s_nxt.cur = s_r.start_a;
            s_nxt.rep_cnt = 8'h0;
            s_nxt.in_sub = 1'b0;
            s_nxt.m_start = s_r.start_a;
            s_nxt.m_stop = s_r.stop_a;
            s_nxt.m_reps = s_r.reps;
            s_nxt.m_default_dwell_time = s_r.default_dwell_time;
          end
          if (wdata_in[step_function_pkg::CMD_ABORT_BIT] && s_r.st != IDLE)
            s_nxt.abort = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd_in) begin
      case (addr_in)
        step_function_pkg::REG_CTRL: s_nxt.rd = {31'h0, s_r.power_fn};
        step_function_pkg::REG_WORK_CODE: s_nxt.rd = {27'h0, s_r.code};
        step_function_pkg::REG_WORK_VSET: s_nxt.rd = {16'h0, s_r.vset};
        step_function_pkg::REG_WORK_ISET: s_nxt.rd = {16'h0, s_r.iset};
        step_function_pkg::REG_WORK_TIME: s_nxt.rd = {16'h0, s_r.step_dwell_time};
        step_function_pkg::REG_STATUS:
          s_nxt.rd = {24'h0, s_r.in_sub, s_r.local_m, s_r.ai, s_r.av,
            s_r.oe, s_r.st != IDLE};
        step_function_pkg::REG_OUT_VSET: s_nxt.rd = {16'h0, s_r.ov};
        step_function_pkg::REG_OUT_ISET: s_nxt.rd = {16'h0, s_r.oi};
        step_function_pkg::REG_READBACK:
          s_nxt.rd = {11'h0, m_code[s_r.loc], m_v[s_r.loc]};
        default: s_nxt.rd = 32'h0;
      endcase
    end
    // ************************************************************
    // sequencer: codes act only here
    // ************************************************************
    // a pending abort freezes the step so no half-entered code acts
    case (s_r.abort ? IDLE : s_r.st)
      IDLE: ;
      ENTER: begin
        s_nxt.st = DWELL;
        // a subsequence runs on its own default time
        s_nxt.dwell = (et != 16'h0) ? et :
          (s_r.in_sub ? s_r.default_dwell_time : s_r.m_default_dwell_time);
        s_nxt.tick = 32'h0;
        s_nxt.ramp_v = 1'b0;
        s_nxt.ramp_i = 1'b0;
        case (ecode)
          step_function_pkg::EMPTY_STEP_CODE: s_nxt.dwell = 16'h0;
          step_function_pkg::NO_FUNCTION_CODE: begin
            s_nxt.ov = ev;
            s_nxt.oi = ei;
          end
          step_function_pkg::VOLTAGE_RAMP_CODE: begin
            s_nxt.ramp_v = 1'b1;
            s_nxt.ramp_from = s_r.ov;
            s_nxt.oi = ei;
          end
          step_function_pkg::CURRENT_RAMP_CODE: begin
            s_nxt.ramp_i = 1'b1;
            s_nxt.ramp_from = s_r.oi;
            s_nxt.ov = ev;
          end
          step_function_pkg::OUTPUT_OFF_CODE,
          step_function_pkg::OUTPUT_ON_CODE: begin
            s_nxt.ov = ev;
            s_nxt.oi = ei;
            s_nxt.oe = ecode[0];
          end
          step_function_pkg::ANALOG_V_OFF_CODE: begin
            s_nxt.ov = ev;
            s_nxt.oi = ei;
            s_nxt.av = step_function_pkg::ANALOG_OFF;
          end
          step_function_pkg::ANALOG_V_ON_CODE: begin
            s_nxt.ov = ev;
            s_nxt.oi = ei;
            s_nxt.av = step_function_pkg::ANALOG_ON;
          end
          step_function_pkg::ANALOG_V_FOLLOW_CODE: begin
            s_nxt.ov = ev;
            s_nxt.oi = ei;
            s_nxt.av = step_function_pkg::ANALOG_FOLLOW;
          end
          step_function_pkg::ANALOG_I_OFF_CODE: begin
            s_nxt.ov = ev;
            s_nxt.oi = ei;
            s_nxt.ai = step_function_pkg::ANALOG_OFF;
          end
          step_function_pkg::ANALOG_I_ON_CODE: begin
            s_nxt.ov = ev;
            s_nxt.oi = ei;
            s_nxt.ai = step_function_pkg::ANALOG_ON;
          end
          step_function_pkg::ANALOG_I_FOLLOW_CODE: begin
            s_nxt.ov = ev;
            s_nxt.oi = ei;
            s_nxt.ai = step_function_pkg::ANALOG_FOLLOW;
          end
          step_function_pkg::CHAIN_CODE: begin
            recall = 1'b1;
            s_nxt.dwell = 16'h0;
            s_nxt.in_sub = 1'b0;
            s_nxt.m_stop = srec[1+16+8+DEPTH_LOG2-1:1+16+8];
            s_nxt.m_start = srec[1+16+8+2*DEPTH_LOG2-1:1+16+8+DEPTH_LOG2];
            s_nxt.m_reps = srec[1+16+7:1+16];
            s_nxt.m_default_dwell_time = srec[16:1];
            s_nxt.m_cnt = 8'h0;
            s_nxt.cur = srec[1+16+8+2*DEPTH_LOG2-1:1+16+8+DEPTH_LOG2];
            s_nxt.st = ENTER;
            if (srec[0]) s_nxt.abort = 1'b1;
          end
          step_function_pkg::SUBSEQ_CODE: begin
            if (!s_r.in_sub) begin
              s_nxt.in_sub = 1'b1;
              s_nxt.ret_a = s_r.cur;
              s_nxt.start_a = srec[1+16+8+2*DEPTH_LOG2-1:1+16+8+DEPTH_LOG2];
              s_nxt.stop_a = srec[1+16+8+DEPTH_LOG2-1:1+16+8];
              s_nxt.reps = srec[1+16+7:1+16];
              s_nxt.default_dwell_time = srec[16:1];
              s_nxt.rep_cnt = 8'h0;
              s_nxt.cur = srec[1+16+8+2*DEPTH_LOG2-1:1+16+8+DEPTH_LOG2];
              s_nxt.st = ENTER;
            end
            s_nxt.dwell = 16'h0;
          end
          default: ;
        endcase
        if ((ecode == step_function_pkg::CHAIN_CODE ||
             ecode == step_function_pkg::SUBSEQ_CODE) &&
            s_r.cur == s_r.m_stop && !s_r.in_sub) begin
          s_nxt.ov = ev;
          s_nxt.oi = ei;
        end
      end
      DWELL: begin
        if (s_r.tick + 32'h1 >= 32'(TICK)) begin
          s_nxt.tick = 32'h0;
          if (s_r.dwell != 16'h0) s_nxt.dwell = s_r.dwell - 16'h1;
          // one step per dwell unit, so the ramp spans the whole dwell
          if (s_r.ramp_v && s_r.dwell != 16'h0)
            s_nxt.ov = ramp_step(s_r.ov, ev, s_r.dwell);
          if (s_r.ramp_i && s_r.dwell != 16'h0)
            s_nxt.oi = ramp_step(s_r.oi, ei, s_r.dwell);
        end else begin
          s_nxt.tick = s_r.tick + 32'h1;
        end
        if (s_r.dwell == 16'h0) begin
          if (s_r.ramp_v) s_nxt.ov = ev;
          if (s_r.ramp_i) s_nxt.oi = ei;
          s_nxt.st = ENTER;
          if (s_r.in_sub && s_r.cur == s_r.stop_a) begin
            if (s_r.reps == 8'h0) begin
              s_nxt.cur = s_r.start_a;
            end else if (s_r.rep_cnt + 8'h1 >= s_r.reps) begin
              s_nxt.in_sub = 1'b0;
              s_nxt.cur = s_r.ret_a + addr_t'(1);
            end else begin
              s_nxt.rep_cnt = s_r.rep_cnt + 8'h1;
              s_nxt.cur = s_r.start_a;
            end
          end else if (!s_r.in_sub && s_r.cur == s_r.m_stop) begin
            if (s_r.m_reps != 8'h0 && s_r.m_cnt + 8'h1 >= s_r.m_reps)
              s_nxt.st = FINISH;
            else begin
              s_nxt.m_cnt = s_r.m_cnt + 8'h1;
              s_nxt.cur = s_r.m_start;
            end
          end else begin
            s_nxt.cur = s_r.cur + addr_t'(1);
          end
        end
      end
      FINISH: begin
        s_nxt.st = IDLE;
        s_nxt.m_cnt = 8'h0;
        if (m_code[s_r.m_stop] == step_function_pkg::EMPTY_STEP_CODE)
          s_nxt.oe = 1'b0;
      end
      default: s_nxt.st = IDLE;
    endcase
    if (s_r.abort) begin
      s_nxt.abort = 1'b0;
      s_nxt.st = IDLE;
      s_nxt.in_sub = 1'b0;
      s_nxt.m_cnt = 8'h0;
      if (m_code[s_r.m_stop] == step_function_pkg::CHAIN_CODE ||
          m_code[s_r.m_stop] == step_function_pkg::SUBSEQ_CODE) begin
        s_nxt.ov = m_v[s_r.m_stop];
        s_nxt.oi = m_i[s_r.m_stop];
      end
    end
    // registered copy, so the pin comes straight from a flip-flop
    s_nxt.run = (s_nxt.st != IDLE);
  end
  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_r <= '0;
      s_r.st <= IDLE;
      s_r.code <= step_function_pkg::CODE_RESET;
      s_r.default_dwell_time <= step_function_pkg::DEFAULT_TIME_RESET;
      s_r.m_default_dwell_time <= step_function_pkg::DEFAULT_TIME_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign rdata_out = s_r.rd;
  assign vset_out = s_r.ov;
  assign iset_out = s_r.oi;
  assign output_enable_setting_out = s_r.oe;
  assign analog_voltage_input_out = s_r.av;
  assign analog_current_input_out = s_r.ai;
  assign running_out = s_r.run;
  assign local_mode_out = s_r.local_m;
endmodule // step_function_engine
`default_nettype wire

// ### step_function_engine_assertions.sv
// concurrent checks on the ports of the step function engine
// assumes one clock domain; bound to every engine instance below
`timescale 1ns/10ps
`default_nettype none
module step_function_engine_checker #(
  parameter int DEPTH_LOG2 = 4,
  parameter int SETUPS = 15,
  parameter int TICK = step_function_pkg::TICK_CYCLES
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic [15:0] vset_out,
  input wire logic [15:0] iset_out,
  input wire logic output_enable_setting_out,
  input wire logic [1:0] analog_voltage_input_out,
  input wire logic [1:0] analog_current_input_out,
  input wire logic running_out,
  input wire logic local_mode_out
);
  // ************************************************************
  // port relations
  // ************************************************************
  logic cmd_wr;
  assign cmd_wr = wr_in && addr_in == step_function_pkg::REG_CMD;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  rdata_quiet_a: assert property (
    !$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data seen outside read slot");
  code_range_a: assert property (
    rd_in && addr_in == step_function_pkg::REG_WORK_CODE
    |=> rdata_out <= 32'h0000_000D)
    else $error("code readback outside defined set");
  // two cycles of grace after a run for the final off switch
  idle_hold_a: assert property (
    !running_out && !$past(running_out) && !$past(running_out, 2)
    |-> $stable(output_enable_setting_out)
    && $stable(analog_voltage_input_out)
    && $stable(analog_current_input_out))
    else $error("switching outputs moved while idle");
  start_run_a: assert property (
    cmd_wr && wdata_in[2] && !wdata_in[3] && !running_out
    |=> running_out)
    else $error("start did not begin a run");
  abort_stop_a: assert property (
    cmd_wr && wdata_in[3] && running_out |-> ##[1:4] !running_out)
    else $error("abort did not end the run");
  local_set_a: assert property (
    cmd_wr && wdata_in[4] |=> local_mode_out)
    else $error("local command ignored");
  remote_clr_a: assert property (
    cmd_wr && wdata_in[5] && !wdata_in[4] |=> !local_mode_out)
    else $error("remote command ignored");
  local_cause_a: assert property (
    $changed(local_mode_out) |-> $past(cmd_wr))
    else $error("local mode moved without a command");
  av_legal_a: assert property (
    analog_voltage_input_out != 2'h3)
    else $error("undefined analog voltage mode");
  ai_legal_a: assert property (
    analog_current_input_out != 2'h3)
    else $error("undefined analog current mode");
  cover property (cmd_wr && wdata_in[2]);
  cover property ($fell(running_out) && output_enable_setting_out);
  cover property (rd_in && addr_in == step_function_pkg::REG_READBACK);
endmodule // step_function_engine_checker
bind step_function_engine step_function_engine_checker #(
  .DEPTH_LOG2(DEPTH_LOG2), .SETUPS(SETUPS), .TICK(TICK)
) step_function_engine_checker_i (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .vset_out(vset_out), .iset_out(iset_out),
  .output_enable_setting_out(output_enable_setting_out),
  .analog_voltage_input_out(analog_voltage_input_out),
  .analog_current_input_out(analog_current_input_out),
  .running_out(running_out), .local_mode_out(local_mode_out));
`default_nettype wire

// ### step_function_pkg.sv
// constants, codes and register offsets of the step function engine
// assumes one clock domain and a simple strobe register port
`default_nettype none
package step_function_pkg;
  // ************************************************************
  // step function codes
  // ************************************************************
  localparam logic [4:0] EMPTY_STEP_CODE = 5'h00;
  localparam logic [4:0] NO_FUNCTION_CODE = 5'h01;
  localparam logic [4:0] VOLTAGE_RAMP_CODE = 5'h02;
  localparam logic [4:0] CURRENT_RAMP_CODE = 5'h03;
  localparam logic [4:0] OUTPUT_OFF_CODE = 5'h04;
  localparam logic [4:0] OUTPUT_ON_CODE = 5'h05;
  localparam logic [4:0] ANALOG_V_OFF_CODE = 5'h06;
  localparam logic [4:0] ANALOG_V_ON_CODE = 5'h07;
  localparam logic [4:0] ANALOG_V_FOLLOW_CODE = 5'h08;
  localparam logic [4:0] ANALOG_I_OFF_CODE = 5'h09;
  localparam logic [4:0] ANALOG_I_ON_CODE = 5'h0A;
  localparam logic [4:0] ANALOG_I_FOLLOW_CODE = 5'h0B;
  localparam logic [4:0] CHAIN_CODE = 5'h0C;
  localparam logic [4:0] SUBSEQ_CODE = 5'h0D;
  // analog input modes
  localparam logic [1:0] ANALOG_OFF = 2'h0;
  localparam logic [1:0] ANALOG_ON = 2'h1;
  localparam logic [1:0] ANALOG_FOLLOW = 2'h2;
  // ************************************************************
  // register offsets (word index)
  // ************************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WORK_CODE = 4'h1;
  localparam logic [3:0] REG_WORK_VSET = 4'h2;
  localparam logic [3:0] REG_WORK_ISET = 4'h3;
  localparam logic [3:0] REG_WORK_TIME = 4'h4;
  localparam logic [3:0] REG_ADDR = 4'h5;
  localparam logic [3:0] REG_CMD = 4'h6;
  localparam logic [3:0] REG_SEQ_CFG = 4'h7;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_OUT_VSET = 4'h9;
  localparam logic [3:0] REG_OUT_ISET = 4'hA;
  localparam logic [3:0] REG_SETUP_CFG = 4'hB;
  localparam logic [3:0] REG_READBACK = 4'hC;
  // command register bits
  localparam int CMD_STORE_BIT = 0;
  localparam int CMD_SETUP_STORE_BIT = 1;
  localparam int CMD_START_BIT = 2;
  localparam int CMD_ABORT_BIT = 3;
  localparam int CMD_LOCAL_BIT = 4;
  localparam int CMD_REMOTE_BIT = 5;
  localparam int CMD_RECALL_BIT = 6;
  // ctrl register bit
  localparam int CTRL_POWER_FN_BIT = 0;
  // reset values
  localparam logic [4:0] CODE_RESET = EMPTY_STEP_CODE;
  localparam logic [15:0] DEFAULT_TIME_RESET = 16'h0001;
  // dwell time unit: one millisecond
  localparam int DWELL_UNIT_NS = 1000000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_CYCLES = DWELL_UNIT_NS / CLK_PERIOD_NS;
endpackage : step_function_pkg
`default_nettype wire
